// >>> adi_acu_model.sv
// Behavioural calling unit for one dialer line.
// Assumes the dialer leads change on mclk; dial time is a short cycle count.
`timescale 1ns/10ps
`default_nettype none

module adi_acu_model
#(
  parameter int NDIG = 3,
  parameter int DIAL = 8
)
(
  input  wire logic                     mclk,
  input  wire logic                     reset_n,
  input  wire adi_pkg::adi_acu_out_type lead_out,
  input  wire logic                     abandon_cmd,
  output var  adi_pkg::adi_acu_in_type  lead_in,
  output var  logic [3:0]               last_digit
);
  int cnt;
  int dly;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lead_in    <= '0;
      last_digit <= 4'h0;
      cnt        <= 0;
      dly        <= 0;
    end
    else
    begin
      lead_in.abandon_call_timeout <= abandon_cmd;
      lead_in.line_occupied        <= lead_out.call_request_lead;
      if (!lead_out.call_request_lead)
      begin
        lead_in.next_digit_request_lead <= 1'b0;
        lead_in.data_set_connected      <= 1'b0;
        cnt                             <= 0;
        dly                             <= 0;
      end
      else if (lead_in.next_digit_request_lead)
      begin
        if (lead_out.digit_present_lead)
        begin
          lead_in.next_digit_request_lead <= 1'b0;
          last_digit                      <= lead_out.digit;
          cnt                             <= cnt + 1;
          dly                             <= 0;
        end
      end
      else if (dly < DIAL)
        dly <= dly + 1;
      // Next request only once the present lead is down again
      else if (!lead_out.digit_present_lead && cnt == NDIG)
        lead_in.data_set_connected <= 1'b1;
      else if (!lead_out.digit_present_lead)
        lead_in.next_digit_request_lead <= 1'b1;
    end
  end
endmodule : adi_acu_model

`default_nettype wire

// >>> adi_dialer.sv
// Four-line automatic dialer interface with an APB register slave.
// Assumes calling-unit leads are asynchronous levels and the APB master runs on mclk.
`timescale 1ns/10ps
`default_nettype none

module adi_dialer
(
  input  wire logic                      mclk,
  input  wire logic                      reset_n,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [adi_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output var  logic [31:0]               prdata,
  output var  logic                      pready,
  output var  logic                      pslverr,
  output var  logic                      irq,
  input  wire adi_pkg::adi_acu_in_type   acu_in  [adi_pkg::NUM_LINES],
  output var  adi_pkg::adi_acu_out_type  acu_out [adi_pkg::NUM_LINES]
);

  localparam int NL = adi_pkg::NUM_LINES;
  localparam int EW = adi_pkg::EV_W;

  function automatic logic [NL-1:0] adi_line_sel(input logic [adi_pkg::ADDR_W-1:0] a);
    logic [NL-1:0] s;
    s = '0;
    for (int k = 0; k < NL; k++)
    begin
      if (a == adi_pkg::LINE0_OFS + 12'(k) * adi_pkg::LINE_STRIDE)
      begin
        s[k] = 1'b1;
      end
    end
    return s;
  endfunction : adi_line_sel

  logic            pready_r;
  logic            pslverr_r;
  logic [31:0]     prdata_r;
  logic            irq_r;
  logic [EW-1:0]   stat_r;
  logic [EW-1:0]   mask_r;
  logic [EW-1:0]   ev_all;
  logic [EW-1:0]   gate_all;
  logic [NL-1:0]   wr_sel;
  logic [NL-1:0]   setup_sel;
  logic            wr_done;
  logic            rd_done;
  logic            setup;
  logic [15:0]     line_word [NL];
  logic [3:0]      line_ev   [NL];
  logic            crq_r     [NL];
  logic            dpr_r     [NL];
  logic            done_r    [NL];
  logic            lie_r     [NL];
  logic [3:0]      digit_r   [NL];
  logic            gie_r;
  logic [4:0]      sync1_r   [NL];
  logic [4:0]      sync2_r   [NL];
  logic [4:0]      prev_r    [NL];

  assign setup     = psel & ~penable;
  assign wr_done   = psel & penable & pready_r & pwrite;
  assign rd_done   = psel & penable & pready_r & ~pwrite;
  assign wr_sel    = wr_done ? adi_line_sel(paddr) : '0;
  assign setup_sel = adi_line_sel(paddr);

  // Group enable lives on line zero only; other lines ignore that bit
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      gie_r <= 1'b0;
    else if (wr_sel[0] && pstrb[0])
      gie_r <= pwdata[adi_pkg::GROUP_IRQ_BIT];
  end

  genvar gi;
  generate
    for (gi = 0; gi < NL; gi++)
    begin : g_line
      logic [4:0] rise;
      logic       pnd_fall;
      logic       wr_lo;

      // Order: power, abandon, connected, occupied, next-digit
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          sync1_r[gi] <= 5'h00;
          sync2_r[gi] <= 5'h00;
          prev_r[gi]  <= 5'h00;
        end
        else
        begin
          sync1_r[gi] <= acu_in[gi];
          sync2_r[gi] <= sync1_r[gi];
          prev_r[gi]  <= sync2_r[gi];
        end
      end

      assign rise     = sync2_r[gi] & ~prev_r[gi];
      assign pnd_fall = prev_r[gi][0] & ~sync2_r[gi][0];
      assign wr_lo    = wr_sel[gi] & pstrb[0];

      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          digit_r[gi] <= adi_pkg::DIGIT_RST;
        else if (wr_sel[gi] && pstrb[1])
          digit_r[gi] <= pwdata[adi_pkg::DIGIT_LSB +: 4];
      end

      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
        begin
          crq_r[gi] <= 1'b0;
          lie_r[gi] <= 1'b0;
        end
        else if (wr_lo)
        begin
          crq_r[gi] <= pwdata[adi_pkg::CALL_REQ_BIT];
          lie_r[gi] <= pwdata[adi_pkg::LINE_IRQ_EN_BIT];
        end
      end

      // A write in the same cycle as acceptance wins: software is starting the next digit
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          dpr_r[gi] <= 1'b0;
        else if (wr_lo)
          dpr_r[gi] <= pwdata[adi_pkg::DIGIT_PRES_BIT];
        else if (pnd_fall)
          dpr_r[gi] <= 1'b0;
      end

      // Events count only while a call is requested
      assign line_ev[gi] = crq_r[gi] ? {rise[4], rise[3], rise[2], rise[0]} : 4'h0;

      // Hardware set beats a software clear in the same cycle
      always_ff @(posedge mclk or negedge reset_n)
      begin
        if (!reset_n)
          done_r[gi] <= 1'b0;
        else if (|line_ev[gi])
          done_r[gi] <= 1'b1;
        else if (wr_lo)
          done_r[gi] <= pwdata[adi_pkg::DONE_BIT];
      end

      // Call request is write-only and reads as zero
      assign line_word[gi] = {sync2_r[gi][4], sync2_r[gi][3], 1'b0, sync2_r[gi][1],
                              digit_r[gi], done_r[gi], lie_r[gi], sync2_r[gi][2],
                              sync2_r[gi][0], 1'b0, (gi == 0) ? gie_r : 1'b0,
                              dpr_r[gi], 1'b0};

      assign acu_out[gi] = '{call_request_lead:  crq_r[gi],
                             digit_present_lead: dpr_r[gi],
                             digit:              digit_r[gi]};

      property p_dpr_clear;
        @(posedge mclk) disable iff (!reset_n)
        (pnd_fall && !wr_lo) |=> !dpr_r[gi] && !acu_out[gi].digit_present_lead;
      endproperty
      property p_done_set;
        @(posedge mclk) disable iff (!reset_n)
        (crq_r[gi] && |rise[4:2] || crq_r[gi] && rise[0]) |=> done_r[gi];
      endproperty
      property p_digit_ld;
        @(posedge mclk) disable iff (!reset_n)
        (wr_sel[gi] && pstrb[1]) |=> acu_out[gi].digit == $past(pwdata[11:8]);
      endproperty

      a_dpr_clear: assert property (p_dpr_clear) else $error("dpr not cleared");
      a_done_set:  assert property (p_done_set) else $error("done not set");
      a_digit_ld:  assert property (p_digit_ld) else $error("digit not loaded");
    end
  endgenerate

  always_comb
  begin
    ev_all   = '0;
    gate_all = '0;
    for (int k = 0; k < NL; k++)
    begin
      ev_all[k*adi_pkg::EV_PER_LINE +: 4]   = line_ev[k];
      gate_all[k*adi_pkg::EV_PER_LINE +: 4] = {4{lie_r[k] & gie_r}};
    end
  end

  // Read clears only the bits that were returned, so a late event is not lost
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      stat_r <= '0;
    else if (rd_done && paddr == adi_pkg::IRQ_STAT_OFS)
      stat_r <= (stat_r & ~prdata_r[EW-1:0]) | ev_all;
    else
      stat_r <= stat_r | ev_all;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      mask_r <= adi_pkg::IRQ_MASK_RST;
    else if (wr_done && paddr == adi_pkg::IRQ_MASK_OFS)
    begin
      if (pstrb[0])
        mask_r[7:0] <= pwdata[7:0];
      if (pstrb[1])
        mask_r[15:8] <= pwdata[15:8];
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
      irq_r <= 1'b0;
    else
      irq_r <= |(stat_r & mask_r & gate_all);
  end

  // Data captured in setup; pready answers in the first access cycle
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end
    else
    begin
      pready_r  <= setup;
      pslverr_r <= 1'b0;
      if (setup)
      begin
        prdata_r <= 32'h0000_0000;
        if (|setup_sel)
        begin
          for (int k = 0; k < NL; k++)
          begin
            if (setup_sel[k] && !pwrite)
              prdata_r <= {16'h0000, line_word[k]};
          end
        end
        else if (paddr == adi_pkg::IRQ_STAT_OFS)
        begin
          if (!pwrite)
            prdata_r <= {16'h0000, stat_r | ev_all};
        end
        else if (paddr == adi_pkg::IRQ_MASK_OFS)
        begin
          if (!pwrite)
            prdata_r <= {16'h0000, mask_r};
        end
        else
          pslverr_r <= 1'b1;
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;
  assign irq     = irq_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  property p_pready;
    s_setup |=> s_access or !psel;
  endproperty
  a_pready: assert property (p_pready) else $error("pready missing after setup");

  property p_irq_gate;
    irq |-> $past(gie_r);
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq without group enable");

  property p_crq_lead;
    (wr_sel[0] && pstrb[0]) |=> acu_out[0].call_request_lead == $past(pwdata[0]);
  endproperty
  a_crq_lead: assert property (p_crq_lead) else $error("call request lead wrong");

  property p_occ_read;
    (s_setup and (!pwrite && paddr == adi_pkg::LINE0_OFS)) |=>
      prdata[adi_pkg::LINE_OCC_BIT] == $past(sync2_r[0][1]);
  endproperty
  a_occ_read: assert property (p_occ_read) else $error("line occupied read wrong");

  property p_stat_set;
    line_ev[0][0] |=> stat_r[adi_pkg::EV_NEXT] ##1 (irq || !(mask_r[0] && lie_r[0] && gie_r)
                      || !stat_r[0]);
  endproperty
  a_stat_set: assert property (p_stat_set) else $error("next digit event lost");

  // Without call request and without a write, done must hold its value
  property p_no_ev_idle;
    (!crq_r[1] && !wr_sel[1]) |=> done_r[1] == $past(done_r[1]);
  endproperty
  a_no_ev_idle: assert property (p_no_ev_idle) else $error("done moved while idle");

endmodule : adi_dialer

`default_nettype wire

// >>> adi_pkg.sv
// Package for the automatic dialer interface: register map, field positions,
// reset values and the lead bundles to and from the calling unit.
// Assumes an APB master with 32-bit data and byte strobes.
package adi_pkg;

  localparam int NUM_LINES = 4;
  localparam int ADDR_W    = 12;

  // Byte addresses, one aligned word each
  localparam logic [11:0] LINE0_OFS    = 12'h000;
  localparam logic [11:0] LINE_STRIDE  = 12'h004;
  localparam logic [11:0] IRQ_STAT_OFS = 12'h010;
  localparam logic [11:0] IRQ_MASK_OFS = 12'h014;

  // Line register fields
  localparam int POWER_OFF_BIT   = 15;
  localparam int ABANDON_BIT     = 14;
  localparam int LINE_OCC_BIT    = 12;
  localparam int DIGIT_LSB       = 8;
  localparam int DONE_BIT        = 7;
  localparam int LINE_IRQ_EN_BIT = 6;
  localparam int DSS_BIT         = 5;
  localparam int NEXT_DIGIT_BIT  = 4;
  localparam int GROUP_IRQ_BIT   = 2;
  localparam int DIGIT_PRES_BIT  = 1;
  localparam int CALL_REQ_BIT    = 0;

  // Event bits in the interrupt status word, four per line
  localparam int EV_PER_LINE  = 4;
  localparam int EV_NEXT      = 0;
  localparam int EV_DSS       = 1;
  localparam int EV_ABANDON   = 2;
  localparam int EV_POWER     = 3;
  localparam int EV_W         = NUM_LINES * EV_PER_LINE;

  localparam logic [3:0]      DIGIT_RST    = 4'h0;
  localparam logic [EV_W-1:0] IRQ_MASK_RST = 16'h0000;

  typedef struct packed {
    logic power_off;
    logic abandon_call_timeout;
    logic data_set_connected;
    logic line_occupied;
    logic next_digit_request_lead;
  } adi_acu_in_type;

  typedef struct packed {
    logic       call_request_lead;
    logic       digit_present_lead;
    logic [3:0] digit;
  } adi_acu_out_type;

endpackage : adi_pkg

// >>> testbench.sv
// Self-checking bench: APB master, read scoreboard, calling unit on line 0.
// Assumes lines 1 to 3 have their leads driven directly by the bench.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  logic                     mclk;
  logic                     reset_n;
  logic                     psel;
  logic                     penable;
  logic                     pwrite;
  logic [11:0]              paddr;
  logic [31:0]              pwdata;
  logic [3:0]               pstrb;
  logic [31:0]              prdata;
  logic                     pready;
  logic                     pslverr;
  logic                     irq;
  logic                     abandon_cmd;
  logic [3:0]               last_digit;
  adi_pkg::adi_acu_in_type  m_in;
  adi_pkg::adi_acu_in_type  tb_in [adi_pkg::NUM_LINES];
  adi_pkg::adi_acu_in_type  din   [adi_pkg::NUM_LINES];
  adi_pkg::adi_acu_out_type dout  [adi_pkg::NUM_LINES];
  logic [32:0]              exp_q [$];
  logic [3:0]               dig   [adi_pkg::NUM_LINES];
  logic [31:0]              v;
  int                       mismatches;
  int                       compares;
  int                       seed;
  int                       cyc;

  adi_dialer u_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .acu_in(din), .acu_out(dout));
  adi_acu_model u_acu (.mclk(mclk), .reset_n(reset_n), .lead_out(dout[0]),
    .abandon_cmd(abandon_cmd), .lead_in(m_in), .last_digit(last_digit));

  always_comb
  begin
    din    = tb_in;
    din[0] = m_in;
  end

  task automatic tally_and_finish();
    $display("compares=%0d mismatches=%0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Request held until pready is sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] dat,
                      input logic [3:0] s);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    pstrb   <= s;
    @(posedge mclk);
    penable <= 1'b1;
    do
      @(posedge mclk);
    while (pready !== 1'b1 && ++n < 50);
    if (n >= 50)
    begin
      mismatches++;
      tally_and_finish();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    // One idle edge so the next call never reassigns psel in this time step
    @(posedge mclk);
  endtask : xfer

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err = 1'b0);
    exp_q.push_back({err, e});
    xfer(1'b0, a, 32'h0, 4'h0);
  endtask : rd

  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    check(irq, 1'b1);
  endtask : wait_irq

  always @(posedge mclk)
    if (psel && penable && pready && !pwrite)
      check({pslverr, prdata}, exp_q.pop_front());

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  initial
  begin
    {reset_n, psel, penable, pwrite, abandon_cmd} = '0;
    {paddr, pwdata, pstrb} = '0;
    foreach (tb_in[k]) tb_in[k] = '0;
    seed = 25497;
    repeat (3) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    rd(12'h000, 32'h0);
    rd(adi_pkg::IRQ_MASK_OFS, 32'h0);
    rd(12'h020, 32'h0, 1'b1);
    for (int k = 0; k < 4; k++)
    begin
      v      = $random(seed);
      dig[k] = v[11:8];
      xfer(1'b1, 12'(k * 4), v, 4'h2);
      rd(12'(k * 4), {20'h0, dig[k], 8'h0});
      check(dout[k].digit, dig[k]);
    end
    xfer(1'b1, adi_pkg::IRQ_MASK_OFS, 32'hFFFF, 4'hF);
    rd(adi_pkg::IRQ_MASK_OFS, 32'hFFFF);
    xfer(1'b1, 12'h000, 32'h45, 4'h1);
    @(posedge mclk);
    check(dout[0].call_request_lead, 1'b1);
    for (int i = 0; i < 3; i++)
    begin
      wait_irq();
      rd(adi_pkg::IRQ_STAT_OFS, 32'h1);
      rd(12'h000, {20'h1, dig[0], 8'hD4});
      repeat (2) @(posedge mclk);
      check(irq, 1'b0);
      v      = $random(seed);
      dig[0] = v[3:0];
      xfer(1'b1, 12'h000, {20'h0, dig[0], 8'h47}, 4'h3);
      @(posedge mclk);
      check(dout[0].digit_present_lead, 1'b1);
      for (int n = 0; n < 40 && dout[0].digit_present_lead !== 1'b0; n++)
        @(posedge mclk);
      check(dout[0].digit_present_lead, 1'b0);
      check(last_digit, dig[0]);
    end
    wait_irq();
    rd(adi_pkg::IRQ_STAT_OFS, 32'h2);
    // Let the connect interrupt drop, or the next wait ends at once
    repeat (2) @(posedge mclk);
    check(irq, 1'b0);
    abandon_cmd <= 1'b1;
    wait_irq();
    rd(adi_pkg::IRQ_STAT_OFS, 32'h4);
    abandon_cmd <= 1'b0;
    xfer(1'b1, 12'h000, 32'h41, 4'h1);
    repeat (4) @(posedge mclk);
    abandon_cmd <= 1'b1;
    repeat (8) @(posedge mclk);
    check(irq, 1'b0);
    rd(adi_pkg::IRQ_STAT_OFS, 32'h4);
    xfer(1'b1, 12'h000, 32'h0, 4'h1);
    @(posedge mclk);
    check(dout[0].call_request_lead, 1'b0);
    // Power-off event on line 1 during a call, group enable still off
    xfer(1'b1, 12'h004, 32'h41, 4'h1);
    tb_in[1] <= 5'h10;
    repeat (6) @(posedge mclk);
    check(irq, 1'b0);
    rd(12'h004, {16'h0, 4'h8, dig[1], 8'hC0});
    rd(adi_pkg::IRQ_STAT_OFS, 32'h80);
    xfer(1'b1, 12'h004, 32'h0, 4'h1);
    for (int k = 1; k < 4; k++)
    begin
      v = $random(seed);
      tb_in[k] <= v[4:0];
    end
    repeat (4) @(posedge mclk);
    for (int k = 1; k < 4; k++)
      rd(12'(k * 4), {16'h0, tb_in[k].power_off, tb_in[k].abandon_call_timeout, 1'b0,
         tb_in[k].line_occupied, dig[k], 2'b0, tb_in[k].data_set_connected,
         tb_in[k].next_digit_request_lead, 4'h0});
    repeat (2) @(posedge mclk);
    tally_and_finish();
  end
endmodule : testbench

`default_nettype wire
